/* hw/mpf_params.svh */
// Constants for the mode-driven pin function multiplexer
`ifndef MPF_PARAMS_SVH
`define MPF_PARAMS_SVH

// ----------------------------------------
// Mode strap codes, {mode_select_b, mode_select_a}
// ----------------------------------------
`define MPF_STRAP_BOOT 2'h0
`define MPF_STRAP_TEST 2'h1
`define MPF_STRAP_SINGLE 2'h2
`define MPF_STRAP_EXPANDED 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MPF_XMASK_RST 1'b1
`define MPF_IRQ_EDGE_RST 1'b0
`define MPF_PA_LATCH_RST 8'h00
`define MPF_PB_LATCH_RST 8'h00
`define MPF_PB_DIR_RST 8'h00
`define MPF_PC_LATCH_RST 8'h00
`define MPF_PC_DIR_RST 8'h00
`define MPF_PD_LATCH_RST 2'h0
`define MPF_PD_DIR_RST 2'h0

// ----------------------------------------
// Port A layout
// ----------------------------------------
`define MPF_PA_FIXED_OUT 8'h70
`define MPF_PA_BIT7 7
`define MPF_PA_BIT3 3
`define MPF_OC_IDX7 4
`define MPF_OC_IDX3 0

`endif

/* hw/mpf_pkg.sv */
// Types shared by the pin function multiplexer
package mpf_pkg;

    typedef enum logic [1:0] {
        MPF_MODE_SINGLE,
        MPF_MODE_BOOT,
        MPF_MODE_EXPANDED,
        MPF_MODE_TEST
    } mpf_mode_t;

    typedef enum logic [1:0] {
        MPF_RD_PORTA,
        MPF_RD_DATA_A,
        MPF_RD_PORTC,
        MPF_RD_PORTD
    } mpf_rdsel_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rnw;
        logic addrCycle;
        logic dataCycle;
        logic opFetch;
    } mpf_bus_t;

    typedef struct packed {
        logic portA;
        logic data_a;
        logic dirB;
        logic portC;
        logic dirC;
        logic portD;
        logic dirD;
    } mpf_wr_t;

endpackage

/* hw/mpf_gpio_port.sv */
// Data latch, direction register and readback of one general-purpose port
`include "mpf_params.svh"

module mpf_gpio_port #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] LATCH_RST = '0,
    parameter logic [WIDTH-1:0] DIR_RST = '0
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic wrLatch,
    input wire logic wrDir,
    input wire logic [WIDTH-1:0] effDir,
    input wire logic [WIDTH-1:0] driverIn,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] latch,
    output logic [WIDTH-1:0] dir,
    output logic [WIDTH-1:0] readback
);

    // Outputs read back what the driver is fed, inputs read the pin
    assign readback = (effDir & driverIn) | (~effDir & pinIn);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            latch <= LATCH_RST;
            dir <= DIR_RST;
        end else begin
            if (wrLatch) begin
                latch <= wrData;
            end
            if (wrDir) begin
                dir <= wrData;
            end
        end
    end

endmodule // mpf_gpio_port

/* hw/mpf_pin_mux.sv */
// Mode latch, interrupt input conditioning and pin function multiplexer
//
// Overview of operation
// R1 - Mask nonmaskable interrupt from reset until cleared
// R2 - Nonmaskable interrupt input is level sensitive
// R3 - Sources drive open-drain, hold low until acknowledged
// R4 - Held-low line retriggers once mask clears
// R5 - Maskable input level-triggered at reset, edge optional
// R6 - Sample two mode inputs at reset
// R7 - Hold mode until next reset
// R8 - Instruction-start low during opcode fetch cycle
// R9 - Port D bit 6: I/O or address strobe
// R10 - Port D bit 7: I/O or read/write
// R11 - Ports B, C, D6/7 GPIO only single-chip/bootstrap
// R12 - Expanded: port B drives upper address
// R13 - Expanded: port C multiplexed address/data
// R14 - Port readback: inputs pin, outputs driver
// R15 - Port A writes latch, drive outputs only
// R16 - Compare-owned port A pins ignore data writes
// R17 - Port A reset: 7,3:0 inputs, 6:4 low
// R18 - Port A bits 7,3 direction from control
// R19 - Port B latch drives only in GPIO modes
// R20 - Port B reset: inputs or upper address
`include "mpf_params.svh"

module mpf_pin_mux
    import mpf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic modeSelectA,
    input wire logic modeSelectB,
    input wire mpf_bus_t cpuBus,
    input wire mpf_wr_t wrStrobe,
    input wire mpf_rdsel_t rdSel,
    input wire logic xMaskClear,
    input wire logic xMaskSet,
    input wire logic irqMask,
    input wire logic irqEdgeWr,
    input wire logic irqEdgeVal,
    input wire logic irqAck,
    input wire logic nonmaskableIrqN,
    input wire logic irqN,
    input wire logic paDir7,
    input wire logic paDir3,
    input wire logic [4:0] ocEnable,
    input wire logic [4:0] ocLevel,
    input wire logic [7:0] portaIn,
    input wire logic [7:0] portbIn,
    input wire logic [7:0] portcPinsIn,
    input wire logic portdBit6In,
    input wire logic portdBit7In,
    output mpf_mode_t opMode,
    output logic modeValid,
    output logic conditionFlagsX,
    output logic irqEdgeMode,
    output logic nmiReq,
    output logic irqReq,
    output logic [7:0] rdData,
    output logic instrStartNOut,
    output logic instrStartNOe,
    output logic [7:0] portaOut,
    output logic [7:0] portaOe,
    output logic [7:0] portbOut,
    output logic [7:0] portbOe,
    output logic [7:0] portcPinsOut,
    output logic [7:0] portcPinsOe,
    output logic portdBit6Out,
    output logic portdBit6Oe,
    output logic portdBit7Out,
    output logic portdBit7Oe
);

    // ----------------------------------------
    // Mode capture
    // ----------------------------------------
    logic [1:0] strap;
    mpf_mode_t strapMode;
    logic busMode;
    assign strap = {modeSelectB, modeSelectA};
    assign strapMode = (strap == `MPF_STRAP_BOOT) ? MPF_MODE_BOOT :
                       (strap == `MPF_STRAP_TEST) ? MPF_MODE_TEST :
                       (strap == `MPF_STRAP_SINGLE) ? MPF_MODE_SINGLE :
                       MPF_MODE_EXPANDED;
    // Straps are taken at the first edge after release, since an
    // asynchronous reset may only load constants
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            opMode <= MPF_MODE_SINGLE;
            modeValid <= 1'b0;
        end else if (!modeValid) begin
            opMode <= strapMode; // [R6]
            modeValid <= 1'b1; // [R7]
        end
    end
    // Bus functions own the pins only in expanded and test modes
    assign busMode = modeValid && ((opMode == MPF_MODE_EXPANDED) || (opMode == MPF_MODE_TEST)); // [R11]

    // ----------------------------------------
    // Nonmaskable interrupt
    // ----------------------------------------
    logic nmiLevel;
    logic next_conditionFlagsX;
    // Level, not edge: a wired-OR line with several pending sources
    // keeps asserting until the last source lets go
    assign nmiLevel = !nonmaskableIrqN; // [R2] [R3]
    // Service entry setting the mask wins over a clear in the same cycle
    assign next_conditionFlagsX = xMaskSet || (conditionFlagsX && !xMaskClear); // [R1]

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            conditionFlagsX <= `MPF_XMASK_RST; // [R1]
            nmiReq <= 1'b0;
        end else begin
            conditionFlagsX <= next_conditionFlagsX;
            nmiReq <= modeValid && nmiLevel && !conditionFlagsX; // [R1] [R4]
        end
    end

    // ----------------------------------------
    // Maskable interrupt
    // ----------------------------------------
    logic irqPrevN;
    logic irqFall;
    logic irqLatch;
    logic irqSource;
    assign irqFall = irqPrevN && !irqN;
    assign irqSource = irqEdgeMode ? irqLatch : !irqN;

    // A falling edge in the same cycle as the acknowledge is kept
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqEdgeMode <= `MPF_IRQ_EDGE_RST; // [R5]
            irqPrevN <= 1'b1;
            irqLatch <= 1'b0;
            irqReq <= 1'b0;
        end else begin
            irqPrevN <= irqN;
            irqReq <= modeValid && irqSource && !irqMask; // [R4]
            if (irqEdgeWr) begin
                irqEdgeMode <= irqEdgeVal; // [R5]
            end
            if (irqFall) begin
                irqLatch <= 1'b1;
            end else if (irqAck) begin
                irqLatch <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Instruction-start strobe
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            instrStartNOut <= 1'b0;
            instrStartNOe <= 1'b0;
        end else begin
            instrStartNOut <= 1'b0;
            instrStartNOe <= modeValid && cpuBus.opFetch; // [R8]
        end
    end

    // ----------------------------------------
    // Port A
    // ----------------------------------------
    logic [7:0] paLatch;
    logic [7:0] paDir;
    logic [7:0] paOcMask;
    logic [7:0] paOcLevel;
    logic [7:0] paDriver;
    logic [7:0] paRead;
    // Compare outputs sit on bits 7..3
    assign paOcMask = {ocEnable, 3'h0};
    assign paOcLevel = {ocLevel, 3'h0};
    // Bits 6:4 are fixed outputs, 2:0 fixed inputs
    always_comb begin
        paDir = `MPF_PA_FIXED_OUT; // [R17]
        paDir[`MPF_PA_BIT7] = ocEnable[`MPF_OC_IDX7] | paDir7; // [R18]
        paDir[`MPF_PA_BIT3] = ocEnable[`MPF_OC_IDX3] | paDir3; // [R18]
    end
    // Compare logic owns a pin while enabled; data writes still
    // land in the latch and show up once the compare lets go
    assign paDriver = (paOcMask & paOcLevel) | (~paOcMask & paLatch); // [R16]
    mpf_gpio_port #(.WIDTH(8), .LATCH_RST(`MPF_PA_LATCH_RST), .DIR_RST(8'h00)) u_porta (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wrData(cpuBus.wdata),
        .wrLatch(wrStrobe.portA), // [R15]
        .wrDir(1'b0),
        .effDir(paDir),
        .driverIn(paDriver),
        .pinIn(portaIn),
        .latch(paLatch),
        .dir(),
        .readback(paRead) // [R14]
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            portaOut <= 8'h00; // [R17]
            portaOe <= `MPF_PA_FIXED_OUT; // [R17]
        end else begin
            portaOut <= paDriver & paDir; // [R15]
            portaOe <= paDir;
        end
    end

    // ----------------------------------------
    // Port B
    // ----------------------------------------
    logic [7:0] pbLatch;
    logic [7:0] pbDir;
    logic [7:0] pbEffDir;
    logic [7:0] pbRead;
    logic [7:0] next_portbOut;
    logic [7:0] next_portbOe;
    assign pbEffDir = busMode ? 8'hFF : pbDir;
    mpf_gpio_port #(.WIDTH(8), .LATCH_RST(`MPF_PB_LATCH_RST), .DIR_RST(`MPF_PB_DIR_RST)) u_data_a (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wrData(cpuBus.wdata),
        .wrLatch(wrStrobe.data_a), // [R19]
        .wrDir(wrStrobe.dirB),
        .effDir(pbEffDir),
        .driverIn(busMode ? cpuBus.addr[15:8] : pbLatch),
        .pinIn(portbIn),
        .latch(pbLatch),
        .dir(pbDir),
        .readback(pbRead) // [R19]
    );

    assign next_portbOut = busMode ? cpuBus.addr[15:8] : (pbLatch & pbDir); // [R12] [R19]
    assign next_portbOe = busMode ? 8'hFF : pbDir; // [R20]
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            portbOut <= 8'h00;
            portbOe <= 8'h00;
        end else begin
            portbOut <= next_portbOut;
            portbOe <= next_portbOe; // [R20]
        end
    end

    // ----------------------------------------
    // Port C
    // ----------------------------------------
    logic [7:0] pcLatch;
    logic [7:0] pcDir;
    logic [7:0] pcRead;
    logic pcDriveBus;
    logic [7:0] next_portcOut;
    logic [7:0] next_portcOe;
    // Address phase drives the low byte; data phase drives only on writes
    assign pcDriveBus = cpuBus.addrCycle || (cpuBus.dataCycle && !cpuBus.rnw); // [R13]
    mpf_gpio_port #(.WIDTH(8), .LATCH_RST(`MPF_PC_LATCH_RST), .DIR_RST(`MPF_PC_DIR_RST)) u_portc (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wrData(cpuBus.wdata),
        .wrLatch(wrStrobe.portC),
        .wrDir(wrStrobe.dirC),
        .effDir(busMode ? 8'h00 : pcDir),
        .driverIn(pcLatch),
        .pinIn(portcPinsIn),
        .latch(pcLatch),
        .dir(pcDir),
        .readback(pcRead) // [R14]
    );

    assign next_portcOut = !busMode ? (pcLatch & pcDir) :
                           cpuBus.addrCycle ? cpuBus.addr[7:0] :
                           cpuBus.wdata; // [R13]
    assign next_portcOe = !busMode ? pcDir : {8{pcDriveBus}}; // [R11] [R13]
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            portcPinsOut <= 8'h00;
            portcPinsOe <= 8'h00;
        end else begin
            portcPinsOut <= next_portcOut;
            portcPinsOe <= next_portcOe;
        end
    end

    // ----------------------------------------
    // Port D bits 6 and 7
    // ----------------------------------------
    logic [1:0] pdLatch;
    logic [1:0] pdDir;
    logic [1:0] pdRead;
    mpf_gpio_port #(.WIDTH(2), .LATCH_RST(`MPF_PD_LATCH_RST), .DIR_RST(`MPF_PD_DIR_RST)) u_portd (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wrData(cpuBus.wdata[7:6]),
        .wrLatch(wrStrobe.portD),
        .wrDir(wrStrobe.dirD),
        .effDir(busMode ? 2'h3 : pdDir),
        .driverIn(busMode ? {cpuBus.rnw, cpuBus.addrCycle} : pdLatch),
        .pinIn({portdBit7In, portdBit6In}),
        .latch(pdLatch),
        .dir(pdDir),
        .readback(pdRead)
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            portdBit6Out <= 1'b0;
            portdBit6Oe <= 1'b0;
            portdBit7Out <= 1'b0;
            portdBit7Oe <= 1'b0;
        end else begin
            portdBit6Out <= busMode ? cpuBus.addrCycle : (pdLatch[0] & pdDir[0]); // [R9]
            portdBit6Oe <= busMode | pdDir[0]; // [R9]
            portdBit7Out <= busMode ? cpuBus.rnw : (pdLatch[1] & pdDir[1]); // [R10]
            portdBit7Oe <= busMode | pdDir[1]; // [R10]
        end
    end

    // ----------------------------------------
    // Readback
    // ----------------------------------------
    logic [7:0] next_rdData;
    // Only bits 7:6 of port D belong to this block; the rest read zero
    assign next_rdData = (rdSel == MPF_RD_PORTA) ? paRead : // [R14]
                         (rdSel == MPF_RD_DATA_A) ? pbRead : // [R19]
                         (rdSel == MPF_RD_PORTC) ? pcRead :
                         {pdRead, 6'h00};
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData <= 8'h00;
        end else begin
            rdData <= next_rdData;
        end
    end

endmodule // mpf_pin_mux

/* sim/mpf_pin_mux_props.sv */
// Concurrent checks on the pin function multiplexer ports
module mpf_pin_mux_props
    import mpf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire mpf_bus_t cpuBus,
    input wire mpf_wr_t wrStrobe,
    input wire logic irqMask,
    input wire logic nonmaskableIrqN,
    input wire logic irqN,
    input wire mpf_mode_t opMode,
    input wire logic modeValid,
    input wire logic conditionFlagsX,
    input wire logic irqEdgeMode,
    input wire logic nmiReq,
    input wire logic irqReq,
    input wire logic instrStartNOut,
    input wire logic instrStartNOe,
    input wire logic [7:0] portaOut,
    input wire logic [7:0] portaOe,
    input wire logic [7:0] portbOut,
    input wire logic [7:0] portbOe,
    input wire logic [7:0] portcPinsOut,
    input wire logic [7:0] portcPinsOe,
    input wire logic portdBit6Out,
    input wire logic portdBit6Oe,
    input wire logic portdBit7Out,
    input wire logic portdBit7Oe
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic busMode = modeValid && (opMode == MPF_MODE_EXPANDED || opMode == MPF_MODE_TEST);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Direction write then a quiet cycle, so the pin state two edges on is that write alone
    sequence s_dir_write;
        !busMode && wrStrobe.dirB ##1 !wrStrobe.dirB;
    endsequence
    chk_reset_state: assert property (
        !modeValid |-> conditionFlagsX && !irqEdgeMode && !nmiReq && portaOe == 8'h70 && !(|(portaOut & 8'h70)))
        else $error("state before mode capture wrong");
    chk_mode_held: assert property (modeValid |=> $stable(opMode))
        else $error("mode changed without reset");
    chk_nmi_masked: assert property (conditionFlagsX |=> !nmiReq)
        else $error("nmi taken while masked");
    chk_nmi_level: assert property (
        modeValid && !conditionFlagsX && !nonmaskableIrqN |=> nmiReq)
        else $error("held nmi line not taken");
    chk_irq_level: assert property (
        modeValid && !irqEdgeMode && !irqMask && !irqN |=> irqReq)
        else $error("level irq not taken");
    chk_fetch_strobe: assert property (
        modeValid |=> instrStartNOe == $past(cpuBus.opFetch) && !instrStartNOut)
        else $error("instruction start strobe wrong");
    chk_bus_upper: assert property (
        busMode |=> portbOe == 8'hFF && portbOut == $past(cpuBus.addr[15:8]))
        else $error("upper address not on port b");
    chk_bus_lower: assert property (
        busMode && cpuBus.addrCycle |=> portcPinsOe == 8'hFF && portcPinsOut == $past(cpuBus.addr[7:0]))
        else $error("low address not on port c");
    chk_bus_read: assert property (
        busMode && cpuBus.dataCycle && cpuBus.rnw && !cpuBus.addrCycle |=> portcPinsOe == 8'h00)
        else $error("port c driven during read");
    chk_strobe_dir: assert property (
        busMode |=> portdBit6Oe && portdBit7Oe && portdBit6Out == $past(cpuBus.addrCycle)
            && portdBit7Out == $past(cpuBus.rnw))
        else $error("strobe or direction pin wrong");
    chk_gpio_dir: assert property (s_dir_write |=> portbOe == $past(cpuBus.wdata, 2))
        else $error("port b direction not applied");
endmodule // mpf_pin_mux_props

bind mpf_pin_mux mpf_pin_mux_props u_props (.*);

/* sim/mpf_irq_src.sv */
// Wired-OR interrupt sources with open-drain drivers and one pull-up
module mpf_irq_src #(
    parameter int N = 2
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [N-1:0] raise,
    input wire logic [N-1:0] ack,
    output logic lineN
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [N-1:0] pending;
    // Each source keeps pulling low until its own request is acknowledged
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pending <= '0;
        end else begin
            pending <= (pending | raise) & ~ack;
        end
    end
    // Pull-up wins only when no driver is active, never a stale level
    assign lineN = ~|pending;
endmodule // mpf_irq_src

/* sim/mpf_pin_mux_tb.sv */
// Self-checking bench for the pin function multiplexer
module mpf_pin_mux_tb
    import mpf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam mpf_wr_t WA = 7'h40, WB = 7'h20, DB = 7'h10, WC = 7'h08, DC = 7'h04, WD = 7'h02, DD = 7'h01;
    logic sys_clk = 0, arst_n = 0, modeSelectA = 0, modeSelectB = 0, bus;
    mpf_bus_t cpuBus = '0;
    mpf_wr_t wrStrobe = '0;
    mpf_rdsel_t rdSel = MPF_RD_PORTA;
    logic xMaskClear = 0, xMaskSet = 0, irqMask = 1, irqEdgeWr = 0, irqEdgeVal = 0, irqAck = 0;
    logic paDir7 = 0, paDir3 = 0;
    logic [4:0] ocEnable = '0, ocLevel = '0;
    logic [7:0] extA = 8'h00, extB = 8'h00, extC = 8'h00;
    logic [1:0] extD = 2'h0, nmiRaise = 2'h0, nmiDone = 2'h0, irqRaise = 2'h0, irqDone = 2'h0;
    wire logic nonmaskableIrqN, irqN;
    mpf_mode_t opMode;
    mpf_mode_t modeOf [4] = '{MPF_MODE_BOOT, MPF_MODE_TEST, MPF_MODE_SINGLE, MPF_MODE_EXPANDED};
    logic modeValid, conditionFlagsX, irqEdgeMode, nmiReq, irqReq, instrStartNOut, instrStartNOe;
    logic [7:0] rdData, portaOut, portaOe, portbOut, portbOe, portcPinsOut, portcPinsOe;
    logic portdBit6Out, portdBit6Oe, portdBit7Out, portdBit7Oe;
    // Pin levels resolved from the DUT's enables; the bench drives every pin the DUT does not
    wire logic [7:0] portaIn = (portaOut & portaOe) | (extA & ~portaOe);
    wire logic [7:0] portbIn = (portbOut & portbOe) | (extB & ~portbOe);
    wire logic [7:0] portcPinsIn = (portcPinsOut & portcPinsOe) | (extC & ~portcPinsOe);
    wire logic portdBit6In = portdBit6Oe ? portdBit6Out : extD[0];
    wire logic portdBit7In = portdBit7Oe ? portdBit7Out : extD[1];
    int miscompares = 0, num_checks = 0, cycles = 0;

    mpf_pin_mux u_dut (.*);
    mpf_irq_src u_nmiSrc (.sys_clk, .arst_n, .raise(nmiRaise), .ack(nmiDone), .lineN(nonmaskableIrqN));
    mpf_irq_src u_irqSrc (.sys_clk, .arst_n, .raise(irqRaise), .ack(irqDone), .lineN(irqN));

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Strobe drops for a full cycle so back-to-back calls never reassign it in one step
    task automatic wr(input mpf_wr_t which, input logic [7:0] d);
        wrStrobe = which;
        cpuBus.wdata = d;
        tick();
        wrStrobe = '0;
        tick();
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick();
        s = 0;
        tick();
    endtask
    task automatic rd(input mpf_rdsel_t s, input logic [7:0] exp);
        rdSel = s;
        tick(2);
        chk("rdData", exp, rdData);
    endtask
    task automatic boot(input logic [1:0] strap);
        arst_n = 0;
        {modeSelectB, modeSelectA} = strap;
        tick(8);
        chk("porta oe rst", 8'h70, portaOe);
        chk("porta out rst", 8'h00, portaOut & 8'h70);
        arst_n = 1;
        tick(2);
        chk("x mask", 1, conditionFlagsX);
        chk("irq edge", 0, irqEdgeMode);
        {modeSelectB, modeSelectA} = ~strap;
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        boot(2'h2);
        paDir7 = 1;
        extA = 8'h05;
        wr(WA, 8'hFF);
        chk("porta oe", 8'hF0, portaOe);
        chk("porta out", 8'hF0, portaOut & portaOe);
        rd(MPF_RD_PORTA, 8'hF5);
        ocEnable = 5'h11;
        ocLevel = 5'h01;
        paDir7 = 0;
        wr(WA, 8'h00);
        chk("porta oe oc", 8'hF8, portaOe);
        chk("porta out oc", 8'h08, portaOut & portaOe);
        rd(MPF_RD_PORTA, 8'h0D);
        ocEnable = '0;
        extB = 8'h5A;
        wr(DB, 8'hF0);
        wr(WB, 8'hC3);
        chk("data_a out", 8'hC0, portbOut & portbOe);
        rd(MPF_RD_DATA_A, 8'hCA);
        extC = 8'h0F;
        wr(DC, 8'h3C);
        wr(WC, 8'hA5);
        chk("portc pins", 16'h3C24, {portcPinsOe, portcPinsOut});
        rd(MPF_RD_PORTC, 8'h27);
        extD = 2'h2;
        rd(MPF_RD_PORTD, 8'h80);
        wr(DD, 8'hC0);
        wr(WD, 8'h40);
        chk("portd pins", 4'hB, {portdBit7Oe, portdBit7Out, portdBit6Oe, portdBit6Out});
        cpuBus.opFetch = 1;
        tick();
        chk("fetch strobe", 2'h2, {instrStartNOe, instrStartNOut});
        cpuBus.opFetch = 0;
        tick();
        chk("fetch idle", 0, instrStartNOe);
        nmiRaise = 2'h3;
        tick();
        nmiRaise = 2'h0;
        tick(3);
        chk("nmi masked", 0, nmiReq);
        pulse(xMaskClear);
        chk("nmi taken", 1, nmiReq);
        nmiDone = 2'h1;
        pulse(xMaskSet);
        nmiDone = 2'h0;
        chk("nmi in service", 0, nmiReq);
        pulse(xMaskClear);
        chk("nmi again", 1, nmiReq);
        nmiDone = 2'h2;
        tick(3);
        chk("nmi released", 0, nmiReq);
        irqRaise = 2'h1;
        tick();
        irqRaise = 2'h0;
        tick(2);
        chk("irq masked", 0, irqReq);
        irqMask = 0;
        tick(2);
        chk("irq level", 1, irqReq);
        irqEdgeVal = 1;
        pulse(irqEdgeWr);
        chk("irq edge set", 1, irqEdgeMode);
        pulse(irqAck);
        tick();
        chk("irq edge held", 0, irqReq);
        irqMask = 1;
        for (int i = 0; i < 4; i++) begin
            boot(i[1:0]);
            bus = i[0];
            chk("mode", modeOf[i], opMode);
            chk("data_a oe", bus ? 8'hFF : 8'h00, portbOe);
            cpuBus.addr = 16'hA55A;
            cpuBus.addrCycle = 1;
            cpuBus.rnw = 1;
            wr(DB, 8'hFF);
            wr(WB, 8'h3C);
            chk("data_a out", bus ? 8'hA5 : 8'h3C, portbOut);
            chk("portd oe", bus ? 2'h3 : 2'h0, {portdBit6Oe, portdBit7Oe});
            if (bus) begin
                chk("pc addr", 16'hFF5A, {portcPinsOe, portcPinsOut});
                chk("pd bus", 2'h3, {portdBit6Out, portdBit7Out});
                cpuBus.addrCycle = 0;
                cpuBus.dataCycle = 1;
                cpuBus.rnw = 0;
                tick(2);
                chk("pc write", 16'hFF3C, {portcPinsOe, portcPinsOut});
                chk("pd bus", 2'h0, {portdBit6Out, portdBit7Out});
                cpuBus.rnw = 1;
                tick(2);
                chk("pc read", 8'h00, portcPinsOe);
            end
            cpuBus = '0;
            chk("mode held", modeOf[i], opMode);
        end
        finish_test();
    end
endmodule // mpf_pin_mux_tb
